// ### core/pmc_pkg.sv
package pmc_pkg;
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFF_CTRL     = 4'h0;
  localparam logic [3:0]  OFF_WAKE     = 4'h4;
  localparam logic [3:0]  OFF_STATUS   = 4'h8;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;
  localparam logic [2:0]  DIV_SLOW_MAX = 3'h1;
  localparam int          FAST_XTAL_CYC = 128;
  localparam int          FAST_RC_CYC   = 16;
  localparam int          SLOW_XTAL_CYC = 1024;
  localparam int          SLOW_RC_CYC   = 2;
  localparam int          CNT_W         = 11;

  typedef struct packed {
    logic       osc_internal;
    logic       detector_enable;
    logic       watchdog_enable;
    logic       fast_wake_enable;
    logic       idle_sysclock_keep;
    logic       idle_select;
    logic [2:0] clock_divider_select;
    logic       fast_clock_select;
  } pmc_ctrl_t;

  localparam pmc_ctrl_t CTRL_RST = 10'h081;

  typedef struct packed {
    logic [2:0] mode;
    logic       sysclk_from_sub;
    logic       slow_osc_ready;
    logic       fast_osc_ready_flag;
    logic       watchdog_timeout_flag;
    logic       power_down_flag;
  } pmc_status_t;

  typedef enum {PMC_RUN, PMC_DEEP, PMC_SUBSTOP, PMC_CORE_OFF_SUBCLOCK_MODE, PMC_CORE_OFF_SYSCLOCK_ON_MODE} pmc_mode_t;
endpackage : pmc_pkg

// ### core/pmc_stab_counter.sv
`timescale 1ns/100ps
module pmc_stab_counter
  import pmc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         start,
  input  wire logic [W-1:0] length,
  output logic              busy,
  output logic              done
);
  initial begin
    if (W < 2) $error("pmc_stab_counter: width too small");
  end

  logic [W-1:0] count;

  // done is combinational so the owner can latch ready in the same edge busy drops
  assign done = busy && (count == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy  <= 1'b0;
      count <= '0;
    end else if (start) begin
      busy  <= 1'b1;
      count <= length - W'(1);
    end else if (busy) begin
      busy  <= (count != '0);
      count <= count - W'(1);
    end
  end
endmodule : pmc_stab_counter

// ### core/pmc_wake_sync.sv
`timescale 1ns/100ps
module pmc_wake_sync #(
  parameter int N = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] enable,
  output logic              wake
);
  initial begin
    if (N < 1) $error("pmc_wake_sync: no pins");
  end

  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] last;
  logic [N-1:0] fall;

  // pins idle high, so reset to ones avoids a false falling edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '1;
      sync <= '1;
      last <= '1;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      assign fall[i] = enable[i] && last[i] && !sync[i];
    end
  endgenerate

  assign wake = |fall;
endmodule : pmc_wake_sync

// ### core/pmc_ctrl.sv
`timescale 1ns/100ps
// Operation
// - fast clock when select set or divider>=010
// - halt, idle off, watchdog/detector off: deep stop
// - deep stop stops all clocks, clears watchdog
// - halt, idle off, watchdog/detector on: subclock stop
// - other modes clear watchdog, it keeps counting
// - idle, keep off: sysclock stops, timebase runs
// - idle, keep on: only program halts
// - entry sets power-down, clears timeout flag
// - wake on port edge, interrupt, watchdog overflow
// - watchdog wake sets timeout, resets pc/sp only
// - power-down cleared by clear-watchdog, set by halt
// - per-pin wake enable, resume after halt
// - masked or stack-full interrupt resumes after halt
// - enabled interrupt with stack room is serviced
// - interrupt pending before entry cannot wake
// - one shared counter, slow after fast
// - deep wake runs only after fast ready, or after slow ready in slow mode
// - fast wake from subclock stop runs on subclock
// - peripherals follow system clock source change
// - subclock follows watchdog/detector enable or slow mode; watchdog clock needs watchdog enable
// - fast ready after 128 crystal or 16 rc cycles
// - fast wake runs subclock until fast ready
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int NPIN = 8,
  parameter int NIRQ = 8
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic            halt_req,
  input  wire logic            clr_wdt,
  input  wire logic            wdt_overflow,
  input  wire logic [NIRQ-1:0] irq_pending,
  input  wire logic [NIRQ-1:0] irq_enable,
  input  wire logic            stack_full,
  input  wire logic [NPIN-1:0] port_a,
  output logic                 sysclk_en,
  output logic                 timebase_clk_en,
  output logic                 wdt_clk_en,
  output logic                 sub_clk_en,
  output logic                 fast_osc_en,
  output logic                 sysclk_from_sub,
  output logic                 core_halted,
  output logic                 wdt_clear,
  output logic                 pc_sp_reset,
  output logic                 core_resume,
  output logic                 irq_service
);
  initial begin
    if (NPIN < 1 || NPIN > 16 || NIRQ < 1) $error("pmc_ctrl: bad size");
  end

  pmc_ctrl_t         ctrl;
  logic [NPIN-1:0]   port_wake_enable;
  pmc_mode_t         mode;
  logic              power_down_flag;
  logic              watchdog_timeout_flag;
  logic              fast_osc_ready_flag;
  logic              slow_osc_ready;
  logic              sub_run;
  logic              cnt_slow;
  logic [NIRQ-1:0]   irq_armed;
  logic              wr_pend;
  logic [ADDR_W-1:0] wr_addr;

  // bus decode
  wire              bus_req  = hsel && hready && htrans == HTRANS_NSEQ;
  wire [ADDR_W-1:0] req_addr = haddr[ADDR_W-1:0];
  pmc_status_t      status;
  assign status = {3'(mode), sysclk_from_sub, slow_osc_ready, fast_osc_ready_flag,
                   watchdog_timeout_flag, power_down_flag};
  wire [31:0] rd_word = (req_addr == OFF_CTRL)   ? 32'(ctrl) :
                        (req_addr == OFF_WAKE)   ? 32'(port_wake_enable) :
                        (req_addr == OFF_STATUS) ? 32'(status) : 32'h0000_0000;

  // mode selection
  wire slow_mode   = !ctrl.fast_clock_select && ctrl.clock_divider_select <= DIV_SLOW_MAX;
  wire sub_needed  = ctrl.watchdog_enable || ctrl.detector_enable || slow_mode;
  wire core_ok     = slow_mode ? slow_osc_ready : (fast_osc_ready_flag || sub_run);
  wire asleep      = mode != PMC_RUN;
  wire halt_ok     = mode == PMC_RUN && halt_req && core_ok;
  pmc_mode_t halt_mode;
  assign halt_mode = ctrl.idle_select ?
                       (ctrl.idle_sysclock_keep ? PMC_CORE_OFF_SYSCLOCK_ON_MODE : PMC_CORE_OFF_SUBCLOCK_MODE) :
                       ((ctrl.watchdog_enable || ctrl.detector_enable) ?
                          PMC_SUBSTOP : PMC_DEEP);

  // wake sources
  logic port_wake;
  pmc_wake_sync #(.N(NPIN)) u_wake (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (port_a),
    .enable  (port_wake_enable),
    .wake    (port_wake)
  );
  wire irq_wake   = |(irq_pending & irq_armed);
  wire irq_ready  = |(irq_pending & irq_armed & irq_enable) && !stack_full;
  wire wake       = asleep && (port_wake || irq_wake || wdt_overflow);
  wire fast_wake  = (mode == PMC_SUBSTOP || mode == PMC_CORE_OFF_SUBCLOCK_MODE) && !ctrl.osc_internal &&
                    ctrl.fast_wake_enable && !slow_mode;

  // oscillator control
  wire fast_on    = !slow_mode && (mode == PMC_RUN || mode == PMC_CORE_OFF_SYSCLOCK_ON_MODE);
  wire sub_on     = sub_needed && mode != PMC_DEEP;
  logic cnt_busy;
  logic cnt_done;
  logic fast_was_on;
  logic sub_was_on;
  // a count left from an oscillator that went off is stale, so it restarts;
  // the fast count cuts a slow one short, and slow starts again after it
  wire start_fast = fast_on && !fast_osc_ready_flag &&
                    (!cnt_busy || cnt_slow || !fast_was_on);
  wire start_slow = sub_on && !slow_osc_ready && !start_fast &&
                    (!cnt_busy || (cnt_slow && !sub_was_on));
  wire [CNT_W-1:0] fast_len = ctrl.osc_internal ? CNT_W'(FAST_RC_CYC) : CNT_W'(FAST_XTAL_CYC);
  wire [CNT_W-1:0] slow_len = ctrl.osc_internal ? CNT_W'(SLOW_RC_CYC) : CNT_W'(SLOW_XTAL_CYC);

  pmc_stab_counter #(.W(CNT_W)) u_cnt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (start_fast || start_slow),
    .length  (start_fast ? fast_len : slow_len),
    .busy    (cnt_busy),
    .done    (cnt_done)
  );

  // bus slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
    end else begin
      hrdata    <= bus_req && !hwrite ? rd_word : 32'h0000_0000;
      wr_pend   <= bus_req && hwrite && hsize == HSIZE_WORD;
      wr_addr   <= req_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl             <= CTRL_RST;
      port_wake_enable <= '0;
    end else if (wr_pend) begin
      if (wr_addr == OFF_CTRL) ctrl <= hwdata[$bits(pmc_ctrl_t)-1:0];
      if (wr_addr == OFF_WAKE) port_wake_enable <= hwdata[NPIN-1:0];
    end
  end

  // mode sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode      <= PMC_RUN;
      irq_armed <= '0;
      sub_run   <= 1'b0;
    end else begin
      case (mode)
        PMC_RUN: begin
          if (halt_ok) mode <= halt_mode;
          if (halt_ok) irq_armed <= ~irq_pending;
          if (fast_osc_ready_flag || slow_mode) sub_run <= 1'b0;
        end
        PMC_DEEP, PMC_SUBSTOP, PMC_CORE_OFF_SUBCLOCK_MODE, PMC_CORE_OFF_SYSCLOCK_ON_MODE: begin
          if (wake) mode <= PMC_RUN;
          if (wake) sub_run <= fast_wake;
        end
        default: mode <= PMC_RUN;
      endcase
    end
  end

  // flags: the set wins over a clear in the same cycle, except the ready flags, where the clear wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down_flag       <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      fast_osc_ready_flag   <= 1'b0;
      slow_osc_ready        <= 1'b0;
      cnt_slow              <= 1'b0;
      fast_was_on           <= 1'b0;
      sub_was_on            <= 1'b0;
    end else begin
      fast_was_on <= fast_on;
      sub_was_on  <= sub_on;
      if (halt_ok) power_down_flag <= 1'b1;
      else if (clr_wdt) power_down_flag <= 1'b0;
      if (wake && wdt_overflow) watchdog_timeout_flag <= 1'b1;
      else if (halt_ok) watchdog_timeout_flag <= 1'b0;
      if (start_fast) cnt_slow <= 1'b0;
      else if (start_slow) cnt_slow <= 1'b1;
      if (!fast_on) fast_osc_ready_flag <= 1'b0;
      else if (cnt_done && !cnt_slow && !start_fast) fast_osc_ready_flag <= 1'b1;
      if (!sub_on) slow_osc_ready <= 1'b0;
      else if (cnt_done && cnt_slow) slow_osc_ready <= 1'b1;
    end
  end

  // registered outputs; a wake releases the core only once core_ok holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysclk_en       <= 1'b1;
      timebase_clk_en <= 1'b1;
      wdt_clk_en      <= 1'b0;
      sub_clk_en      <= 1'b0;
      fast_osc_en     <= 1'b0;
      sysclk_from_sub <= 1'b0;
      core_halted     <= 1'b1;
      wdt_clear       <= 1'b0;
      pc_sp_reset     <= 1'b0;
      core_resume     <= 1'b0;
      irq_service     <= 1'b0;
    end else begin
      sysclk_en       <= mode == PMC_RUN || mode == PMC_CORE_OFF_SYSCLOCK_ON_MODE;
      timebase_clk_en <= mode == PMC_RUN || mode == PMC_CORE_OFF_SUBCLOCK_MODE || mode == PMC_CORE_OFF_SYSCLOCK_ON_MODE;
      wdt_clk_en      <= ctrl.watchdog_enable && sub_on;
      sub_clk_en      <= sub_on;
      fast_osc_en     <= fast_on;
      sysclk_from_sub <= slow_mode || (sub_run && !fast_osc_ready_flag);
      core_halted     <= asleep || !core_ok;
      wdt_clear       <= halt_ok || (clr_wdt && mode == PMC_RUN);
      pc_sp_reset     <= wake && wdt_overflow;
      core_resume     <= wake && !wdt_overflow && !(irq_wake && irq_ready);
      irq_service     <= wake && !wdt_overflow && irq_wake && irq_ready;
    end
  end

  // checks
  property p_deep_entry;
    @(posedge hclk) disable iff (!hresetn)
    halt_ok && !ctrl.idle_select && !ctrl.watchdog_enable && !ctrl.detector_enable
      |=> mode == PMC_DEEP ##1 (!sysclk_en && !wdt_clk_en && !timebase_clk_en);
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep stop not entered");

  property p_sub_entry;
    @(posedge hclk) disable iff (!hresetn)
    halt_ok && !ctrl.idle_select && ctrl.watchdog_enable |=> mode == PMC_SUBSTOP ##1 wdt_clk_en;
  endproperty
  a_sub_entry: assert property (p_sub_entry) else $error("subclock stop wrong");

  property p_entry_flags;
    @(posedge hclk) disable iff (!hresetn)
    halt_ok |=> wdt_clear && power_down_flag && !watchdog_timeout_flag;
  endproperty
  a_entry_flags: assert property (p_entry_flags) else $error("entry flags wrong");

  property p_pdf_clear;
    @(posedge hclk) disable iff (!hresetn)
    clr_wdt && !halt_ok |=> !power_down_flag;
  endproperty
  a_pdf_clear: assert property (p_pdf_clear) else $error("power-down not cleared");

  property p_wdt_wake;
    @(posedge hclk) disable iff (!hresetn)
    asleep && wdt_overflow |=> pc_sp_reset && watchdog_timeout_flag && !irq_service;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_irq_service;
    @(posedge hclk) disable iff (!hresetn)
    asleep && irq_wake && irq_ready && !wdt_overflow |=> irq_service && !core_resume;
  endproperty
  a_irq_service: assert property (p_irq_service) else $error("interrupt not serviced");

  property p_irq_resume;
    @(posedge hclk) disable iff (!hresetn)
    asleep && irq_wake && !irq_ready && !wdt_overflow |=> core_resume && !irq_service;
  endproperty
  a_irq_resume: assert property (p_irq_resume) else $error("interrupt resume wrong");

  property p_fast_xtal;
    @(posedge hclk) disable iff (!hresetn)
    start_fast && !ctrl.osc_internal && !$changed(ctrl) |=> !fast_osc_ready_flag ##128
      (fast_osc_ready_flag || !fast_on || $changed(ctrl));
  endproperty
  a_fast_xtal: assert property (p_fast_xtal) else $error("fast ready timing wrong");

  property p_core_hold;
    @(posedge hclk) disable iff (!hresetn)
    mode == PMC_RUN && !core_ok |=> core_halted;
  endproperty
  a_core_hold: assert property (p_core_hold) else $error("core ran before ready");

  property p_core_off_subclock_mode_entry;
    @(posedge hclk) disable iff (!hresetn)
    halt_ok && ctrl.idle_select && !ctrl.idle_sysclock_keep
      |=> mode == PMC_CORE_OFF_SUBCLOCK_MODE ##1 (!sysclk_en && timebase_clk_en);
  endproperty
  a_core_off_subclock_mode_entry: assert property (p_core_off_subclock_mode_entry) else $error("idle without clock wrong");

  property p_core_off_sysclock_on_mode_entry;
    @(posedge hclk) disable iff (!hresetn)
    halt_ok && ctrl.idle_select && ctrl.idle_sysclock_keep
      |=> mode == PMC_CORE_OFF_SYSCLOCK_ON_MODE ##1 (sysclk_en && timebase_clk_en && core_halted);
  endproperty
  a_core_off_sysclock_on_mode_entry: assert property (p_core_off_sysclock_on_mode_entry) else $error("idle with clock wrong");

  property p_port_resume;
    @(posedge hclk) disable iff (!hresetn)
    asleep && port_wake && !wdt_overflow && !irq_wake |=> core_resume && mode == PMC_RUN;
  endproperty
  a_port_resume: assert property (p_port_resume) else $error("port wake wrong");

  property p_sub_clock;
    @(posedge hclk) disable iff (!hresetn)
    ctrl.watchdog_enable && mode != PMC_DEEP |=> sub_clk_en && wdt_clk_en;
  endproperty
  a_sub_clock: assert property (p_sub_clock) else $error("subclock stopped");

  property p_fast_wake;
    @(posedge hclk) disable iff (!hresetn)
    wake && fast_wake |=> mode == PMC_RUN ##1 (!core_halted && sysclk_from_sub);
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("fast wake wrong");

  property p_slow_source;
    @(posedge hclk) disable iff (!hresetn)
    !ctrl.fast_clock_select && ctrl.clock_divider_select <= DIV_SLOW_MAX |=> sysclk_from_sub;
  endproperty
  a_slow_source: assert property (p_slow_source) else $error("slow source wrong");

  property p_fast_source;
    @(posedge hclk) disable iff (!hresetn)
    (ctrl.fast_clock_select || ctrl.clock_divider_select > DIV_SLOW_MAX) && !sub_run
      |=> !sysclk_from_sub;
  endproperty
  a_fast_source: assert property (p_fast_source) else $error("fast source wrong");

  c_deep_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    mode == PMC_DEEP && wake);
  c_fast_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    wake && fast_wake);
  c_port_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    asleep && port_wake);
  c_core_off_sysclock_on_mode: cover property (@(posedge hclk) disable iff (!hresetn)
    halt_ok && halt_mode == PMC_CORE_OFF_SYSCLOCK_ON_MODE);
  c_irq_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    asleep && irq_wake && irq_ready);
endmodule : pmc_ctrl

// ### tb/pmc_core_model.sv
`timescale 1ns/100ps
module pmc_core_model (
  input  wire logic       hclk,
  input  wire logic       core_halted,
  output logic            halt_req,
  output logic            clr_wdt,
  output logic            wdt_overflow,
  output logic [7:0]      irq_pending,
  output logic [7:0]      irq_enable,
  output logic            stack_full,
  output logic [7:0]      port_a
);
  initial begin
    halt_req = 1'h0;
    clr_wdt = 1'h0;
    wdt_overflow = 1'h0;
    irq_pending = 8'h00;
    irq_enable = 8'h00;
    stack_full = 1'h0;
    port_a = 8'hFF;
  end
  // a core that is held cannot execute a halt, so wait for it to run
  task automatic halt;
    while (core_halted !== 1'h0) @(posedge hclk);
    halt_req <= 1'h1;
    @(posedge hclk);
    halt_req <= 1'h0;
  endtask : halt
  task automatic clr;
    clr_wdt <= 1'h1;
    @(posedge hclk);
    clr_wdt <= 1'h0;
  endtask : clr
  task automatic ovf;
    wdt_overflow <= 1'h1;
    @(posedge hclk);
    wdt_overflow <= 1'h0;
  endtask : ovf
  task automatic irq(input logic [7:0] p, input logic [7:0] e, input logic s);
    irq_pending <= p;
    irq_enable <= e;
    stack_full <= s;
  endtask : irq
  // low long enough to pass the pin synchroniser, then back to idle high
  task automatic pin_fall(input int i);
    port_a[i] <= 1'h0;
    repeat (6) @(posedge hclk);
    port_a[i] <= 1'h1;
    @(posedge hclk);
  endtask : pin_fall
endmodule : pmc_core_model

// ### tb/power_mode_controller_test.sv
`timescale 1ns/100ps
module power_mode_controller_test;
  import pmc_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        halt_req, clr_wdt, wdt_overflow, stack_full;
  logic [7:0]  irq_pending, irq_enable, port_a;
  logic        sysclk_en, timebase_clk_en, wdt_clk_en, sub_clk_en, fast_osc_en;
  logic        sysclk_from_sub, core_halted, wdt_clear, pc_sp_reset, core_resume, irq_service;
  logic [31:0] rd;
  int          fails, n_checks, cnt;
  int          ev [4];
  int          ev0 [4];
  logic [9:0]  ctl_tab [4];
  logic [3:0]  en_tab [4];
  logic        hresp;

  pmc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .halt_req(halt_req), .clr_wdt(clr_wdt), .wdt_overflow(wdt_overflow),
    .irq_pending(irq_pending), .irq_enable(irq_enable), .stack_full(stack_full),
    .port_a(port_a), .sysclk_en(sysclk_en), .timebase_clk_en(timebase_clk_en),
    .wdt_clk_en(wdt_clk_en), .sub_clk_en(sub_clk_en), .fast_osc_en(fast_osc_en),
    .sysclk_from_sub(sysclk_from_sub), .core_halted(core_halted),
    .wdt_clear(wdt_clear), .pc_sp_reset(pc_sp_reset), .core_resume(core_resume),
    .irq_service(irq_service));
  pmc_core_model core (.hclk(hclk), .core_halted(core_halted), .halt_req(halt_req),
    .clr_wdt(clr_wdt), .wdt_overflow(wdt_overflow), .irq_pending(irq_pending),
    .irq_enable(irq_enable), .stack_full(stack_full), .port_a(port_a));

  initial hclk = 1'h0;
  always #10 hclk = ~hclk;
  // pulses are one cycle wide, so count them rather than poll them
  always @(posedge hclk) begin
    ev[0] += core_resume;
    ev[1] += irq_service;
    ev[2] += pc_sp_reset;
    ev[3] += wdt_clear;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {28'h0, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic wait_run;
    cnt = 0;
    while (core_halted !== 1'h0 && cnt < 3000) begin
      @(posedge hclk);
      cnt++;
    end
    chk(core_halted, 32'h0);
  endtask : wait_run
  task automatic wait_sub(input logic v);
    cnt = 0;
    while (sysclk_from_sub !== v && cnt < 3000) begin
      @(posedge hclk);
      cnt++;
    end
    chk(sysclk_from_sub, v);
  endtask : wait_sub
  task automatic sleep(input logic [9:0] c, input logic [2:0] m, input logic [3:0] en);
    bus(1'h1, OFF_CTRL, {22'h0, c});
    ev0 = ev;
    core.halt();
    repeat (3) @(posedge hclk);
    chk({sysclk_en, timebase_clk_en, wdt_clk_en, core_halted}, en);
    chk({sub_clk_en, fast_osc_en}, {en[1], en[3]});
    chk(ev[3] - ev0[3], 1);
    bus(1'h0, OFF_STATUS, 32'h0);
    chk(rd & 32'hE3, {24'h0, m, 5'h01});
  endtask : sleep
  task automatic end_of_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial begin
    #400000;
    fails++;
    end_of_test();
  end

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    ctl_tab[0] = 10'h001;
    ctl_tab[1] = 10'h081;
    ctl_tab[2] = 10'h091;
    ctl_tab[3] = 10'h0B1;
    en_tab[0] = 4'h1;
    en_tab[1] = 4'h3;
    en_tab[2] = 4'h7;
    en_tab[3] = 4'hF;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, OFF_CTRL, 32'h0);
    chk(rd, 32'h81);
    chk(hresp, 32'h0);
    bus(1'h1, 4'hC, 32'hFFFF_FFFF);
    bus(1'h0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    wait_run();
    bus(1'h0, OFF_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h4);
    bus(1'h1, OFF_WAKE, 32'h08);
    for (int i = 0; i < 4; i++) begin
      sleep(ctl_tab[i], 3'(i + 1), en_tab[i]);
      ev0 = ev;
      core.pin_fall(2);
      chk(ev[0] - ev0[0], 0);
      core.pin_fall(3);
      chk(ev[0] - ev0[0], 1);
      wait_run();
      if (i == 0)
        chk(cnt >= 115 && cnt <= 140, 1);
    end
    core.clr();
    bus(1'h0, OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    sleep(10'h081, 3'h2, 4'h3);
    ev0 = ev;
    core.ovf();
    repeat (2) @(posedge hclk);
    chk(ev[2] - ev0[2], 1);
    chk(ev[0] - ev0[0], 0);
    wait_run();
    bus(1'h0, OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
    for (int j = 0; j < 3; j++) begin
      sleep(10'h081, 3'h2, 4'h3);
      ev0 = ev;
      core.irq(8'h01, {7'h0, j < 2}, j == 1);
      repeat (4) @(posedge hclk);
      chk(ev[1] - ev0[1], j == 0);
      chk(ev[0] - ev0[0], j != 0);
      core.irq(8'h00, 8'h01, 1'h0);
      wait_run();
    end
    core.irq(8'h01, 8'h01, 1'h0);
    sleep(10'h081, 3'h2, 4'h3);
    repeat (10) @(posedge hclk);
    chk(ev[0] + ev[1] - ev0[0] - ev0[1], 0);
    core.pin_fall(3);
    core.irq(8'h00, 8'h01, 1'h0);
    wait_run();
    sleep(10'h0C1, 3'h2, 4'h3);
    core.pin_fall(3);
    chk({core_halted, sysclk_from_sub}, 2'h1);
    wait_sub(1'h0);
    wait_run();
    bus(1'h1, OFF_CTRL, 32'h082);
    wait_sub(1'h1);
    bus(1'h1, OFF_CTRL, 32'h084);
    wait_sub(1'h0);
    end_of_test();
  end
endmodule : power_mode_controller_test
